// file: core/pwr_halt_device.sv
// device end: power-down, halt and pin-state control of the mcu core
// assumes: power-sequencing controller on pwr_link_if; the core beside
// this block presents fetched opcodes and takes run_enable/pc back
//
// Contract
// (R1) reset low then power save low stops oscillator
// (R2) ram kept during ram-retention power-down
// (R3) controller raises power save before reset
// (R4) ram-hold exit restarts at address zero
// (R5) reset held 10 us around power save
// (R6) reset low 10 ms before power save
// (R7) single step low then power save stops all
// (R8) controller raises power save before single step
// (R9) full-state exit resumes exact prior state
// (R10) single step held 10 us around power save
// (R11) opcode 01h decodes as halt
// (R12) halt instruction enters halt mode at once
// (R13) halt keeps oscillator, freezes clocks and state
// (R14) halt ends only on reset or interrupt
// (R15) halt released by reset restarts at 000h
// (R16) ei release: one instruction, then service
// (R17) di release: resume after halt
// (R18) ports keep driving prior values in halt
// (R19) halt keeps test zero, ignores t1 ss ea
// (R20) power-down turns off reset and ss pull-ups
// (R21) power-down ignores interrupt and external access
// (R22) power-down floats bus, ports, strobes, test zero
// (R23) halt: strobes high, address latch strobe low
`timescale 1ns/1ps
module pwr_halt_device #(
    parameter int PC_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    pwr_link_if.device link,
    input wire logic opcode_valid, // a fetched opcode is executing
    input wire logic [7:0] opcode,
    input wire logic interrupt_request_input_n,
    input wire logic interrupts_enabled_state, // high: ei, low: di
    input wire logic test_one_input,
    input wire logic external_access_input,
    input wire logic [7:0] bus_out, // core values for the pins
    input wire logic [7:0] first_quasi_out,
    input wire logic [7:0] second_quasi_out,
    input wire logic test_zero_out,
    input wire logic [4:0] strobe_core_n, // rd wr expander_strobe program_store_strobe, ale hi
    output logic run_enable, // core clocks gated on
    output logic core_init, // pulse: core reinitialises
    output logic irq_pending, // pulse: vector to service routine
    output logic [PC_W-1:0] pc_value,
    output logic ram_write_allow, // low while ram must be kept
    output logic test_one_seen,
    output logic external_access_seen,
    output logic [7:0] bus_port_lines,
    output logic bus_port_lines_oe,
    output logic [7:0] first_quasi_port,
    output logic first_quasi_port_oe,
    output logic [7:0] second_quasi_port,
    output logic second_quasi_port_oe,
    output logic test_zero_pin,
    output logic test_zero_pin_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic expander_strobe_n,
    output logic program_store_strobe_n,
    output logic address_latch_strobe,
    output logic strobes_oe,
    output logic [2:0] mode_code
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pwr_halt_pkg::mode_t mode, next_mode; // current device mode
    logic [PC_W-1:0] pc, next_pc; // program address
    logic step_after, next_step_after; // one more instr then isr
    logic init_p, next_init_p;
    logic irq_p, next_irq_p;
    logic [7:0] bus_q, next_bus_q; // frozen pin values
    logic [7:0] p1_q, next_p1_q;
    logic [7:0] p2_q, next_p2_q;
    logic t0_q, next_t0_q;
    logic t1_q, next_t1_q;
    logic ea_q, next_ea_q;
    logic is_halt_op; // decoded halt instruction
    logic down; // any oscillator-stopped mode

    // [R11] halt opcode decode
    assign is_halt_op = opcode_valid && (opcode == pwr_halt_pkg::HALT_OPCODE);
    assign down = (mode == pwr_halt_pkg::MODE_RAM_HOLD) ||
        (mode == pwr_halt_pkg::MODE_ALL_HOLD);

    // ------------------------------------------------------------
    // mode and program flow
    // ------------------------------------------------------------
    // reset first; power save honoured once reset is low, or once ss is low in run (halt ignores ss)
    always_comb begin
        next_mode = mode;
        next_pc = pc;
        next_step_after = step_after;
        next_init_p = 1'b0;
        next_irq_p = 1'b0;
        case (mode)
            pwr_halt_pkg::MODE_RUN: begin
                if (!link.reset_n) begin
                    next_mode = pwr_halt_pkg::MODE_RESET;
                end else if (!link.single_step_input_n &&
                    !link.power_save_input_n) begin
                    next_mode = pwr_halt_pkg::MODE_ALL_HOLD; // [R7]
                end else if (is_halt_op) begin
                    next_mode = pwr_halt_pkg::MODE_HALT; // [R12]
                    next_pc = pc + pwr_halt_pkg::PC_STEP;
                end else if (opcode_valid) begin
                    next_pc = pc + pwr_halt_pkg::PC_STEP;
                    if (step_after) begin
                        // [R16] one instruction done, now service
                        next_step_after = 1'b0;
                        next_irq_p = 1'b1;
                    end
                end
            end
            pwr_halt_pkg::MODE_HALT: begin
                // [R13] pc and all state held; [R14] only two exits
                if (!link.reset_n) begin
                    next_mode = pwr_halt_pkg::MODE_RESET; // [R15]
                end else if (!interrupt_request_input_n) begin
                    next_mode = pwr_halt_pkg::MODE_RUN;
                    // [R16] [R17] pc already at next address
                    next_step_after = interrupts_enabled_state;
                end
            end
            pwr_halt_pkg::MODE_RESET: begin
                next_pc = pwr_halt_pkg::RESET_VECTOR; // [R4] [R15]
                next_step_after = 1'b0;
                if (!link.power_save_input_n) begin
                    next_mode = pwr_halt_pkg::MODE_RAM_HOLD; // [R1]
                end else if (link.reset_n) begin
                    next_mode = pwr_halt_pkg::MODE_RUN;
                    next_init_p = 1'b1; // [R4]
                end
            end
            pwr_halt_pkg::MODE_RAM_HOLD: begin
                // [R20] reset ignored; power save restarts [R3]
                if (link.power_save_input_n) begin
                    next_mode = pwr_halt_pkg::MODE_RESET;
                end
            end
            pwr_halt_pkg::MODE_ALL_HOLD: begin
                // [R9] no init, pc untouched; [R8] ss seen later
                if (link.power_save_input_n) begin
                    next_mode = pwr_halt_pkg::MODE_RUN;
                end
            end
            default: begin
                next_mode = pwr_halt_pkg::MODE_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin values
    // ------------------------------------------------------------
    // pins follow the core in run, quasi ports set high in reset, frozen otherwise
    always_comb begin
        next_bus_q = bus_q;
        next_p1_q = p1_q;
        next_p2_q = p2_q;
        next_t0_q = t0_q;
        next_t1_q = t1_q;
        next_ea_q = ea_q;
        if (mode == pwr_halt_pkg::MODE_RUN) begin
            next_bus_q = bus_out;
            next_p1_q = first_quasi_out;
            next_p2_q = second_quasi_out;
            next_t0_q = test_zero_out;
            next_t1_q = test_one_input;
            next_ea_q = external_access_input;
        end else if (mode == pwr_halt_pkg::MODE_RESET) begin
            next_p1_q = pwr_halt_pkg::PORT_RESET;
            next_p2_q = pwr_halt_pkg::PORT_RESET;
        end
        // [R18] [R19] halt and power-down keep the last values
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= pwr_halt_pkg::MODE_RESET;
            pc <= pwr_halt_pkg::RESET_VECTOR;
            step_after <= 1'b0;
            init_p <= 1'b0;
            irq_p <= 1'b0;
            bus_q <= pwr_halt_pkg::BYTE_ZERO;
            p1_q <= pwr_halt_pkg::PORT_RESET;
            p2_q <= pwr_halt_pkg::PORT_RESET;
            t0_q <= 1'b0;
            t1_q <= 1'b0;
            ea_q <= 1'b0;
        end else begin
            mode <= next_mode;
            pc <= next_pc;
            step_after <= next_step_after;
            init_p <= next_init_p;
            irq_p <= next_irq_p;
            bus_q <= next_bus_q;
            p1_q <= next_p1_q;
            p2_q <= next_p2_q;
            t0_q <= next_t0_q;
            t1_q <= next_t1_q;
            ea_q <= next_ea_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic is_run, is_halt;
    assign is_run = (mode == pwr_halt_pkg::MODE_RUN);
    assign is_halt = (mode == pwr_halt_pkg::MODE_HALT);
    assign run_enable = is_run; // [R13] core clock gate
    assign core_init = init_p;
    assign irq_pending = irq_p;
    assign pc_value = pc;
    assign ram_write_allow = is_run; // [R2] ram frozen otherwise
    assign test_one_seen = t1_q; // [R19] stale outside run
    assign external_access_seen = ea_q; // [R19] [R21]
    assign bus_port_lines = bus_q;
    assign first_quasi_port = p1_q;
    assign second_quasi_port = p2_q;
    assign test_zero_pin = t0_q;
    assign bus_port_lines_oe = !down; // [R22] [R18]
    assign first_quasi_port_oe = !down; // [R22]
    assign second_quasi_port_oe = !down; // [R22]
    assign test_zero_pin_oe = !down; // [R22] [R19]
    assign strobes_oe = !down; // [R22]
    // [R23] fixed in halt, core levels else
    assign read_strobe_n = is_halt | strobe_core_n[0];
    assign write_strobe_n = is_halt | strobe_core_n[1];
    assign expander_strobe_n = is_halt | strobe_core_n[2];
    assign program_store_strobe_n = is_halt | strobe_core_n[3];
    assign address_latch_strobe = !is_halt & strobe_core_n[4];
    assign link.osc_running = !down; // [R1] [R7]
    assign link.reset_pullup_en = !down; // [R20]
    assign link.single_step_pullup_en = !down; // [R20]
    // [R21] interrupt read only in halt
    assign mode_code = {down, is_halt, is_run};
endmodule : pwr_halt_device

// file: core/pwr_halt_pkg.sv
// shared constants of the power-down and halt block
// assumes: one clock core_clk at 20 MHz, active-low async reset rst_n
package pwr_halt_pkg;
    // ------------------------------------------------------------
    // timing and cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50; // core_clk period
    localparam int HOLD_TIME_US = 10; // reset or single-step hold
    localparam int SETUP_TIME_MS = 10; // reset setup before power save
    // least times round up to whole cycles
    localparam int HOLD_CYCLES =
        (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES =
        (SETUP_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // instruction codes and vectors
    // ------------------------------------------------------------
    localparam logic [7:0] HALT_OPCODE = 8'h01; // added halt opcode
    localparam logic [11:0] RESET_VECTOR = 12'h000; // start after reset
    localparam logic [11:0] PC_STEP = 12'h001; // next address
    localparam logic [7:0] PORT_RESET = 8'hff; // quasi ports reset high
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ------------------------------------------------------------
    // device modes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        MODE_RUN = 5'h01, // normal execution
        MODE_HALT = 5'h02, // clocks frozen, osc running
        MODE_RAM_HOLD = 5'h04, // osc stopped, ram kept
        MODE_ALL_HOLD = 5'h08, // osc stopped, all kept
        MODE_RESET = 5'h10 // reset held, not powered down
    } mode_t;
    // controller sequencing states, one-hot
    typedef enum logic [6:0] {
        SEQ_IDLE = 7'h01, // normal running
        SEQ_RST_SETUP = 7'h02, // reset low, waiting setup time
        SEQ_RAM_DOWN = 7'h04, // in ram-retention power-down
        SEQ_RST_HOLD = 7'h08, // ps high, reset still low
        SEQ_SS_SETUP = 7'h10, // ss low, waiting hold
        SEQ_ALL_DOWN = 7'h20, // in full-state power-down
        SEQ_SS_HOLD = 7'h40 // ps high, ss still low
    } seq_t;
endpackage : pwr_halt_pkg

// file: core/pwr_link_if.sv
// interface joining the device and the power-sequencing controller
// assumes: both ends clocked by core_clk
`timescale 1ns/1ps
interface pwr_link_if;
    logic power_save_input_n; // low requests oscillator stop
    logic single_step_input_n; // low selects full-state hold
    logic reset_n; // device reset, active low
    logic reset_pullup_en; // device pull-up on reset active
    logic single_step_pullup_en; // device pull-up on single step
    logic osc_running; // device oscillator running
    // ------------------------------------------------------------
    // one modport per end
    // ------------------------------------------------------------
    modport device (
        input power_save_input_n,
        input single_step_input_n,
        input reset_n,
        output reset_pullup_en,
        output single_step_pullup_en,
        output osc_running
    );
    modport controller (
        output power_save_input_n,
        output single_step_input_n,
        output reset_n,
        input reset_pullup_en,
        input single_step_pullup_en,
        input osc_running
    );
endinterface : pwr_link_if

// file: core/pwr_seq_timer.sv
// down-counter for the controller's minimum wait times
// assumes: load pulses from the owning state machine; counts down on its own
`timescale 1ns/1ps
module pwr_seq_timer #(
    parameter int WIDTH = 18
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);
    logic [WIDTH-1:0] count; // cycles still to wait
    logic [WIDTH-1:0] next_count;
    // ------------------------------------------------------------
    // next count
    // ------------------------------------------------------------
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end
    // registered count
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
    assign done = (count == '0) && !load;
endmodule : pwr_seq_timer

// file: core/pwr_seq_controller.sv
// controller end: drives power save, single step and reset in order
// assumes: device on pwr_link_if; user requests are single-cycle pulses
`timescale 1ns/1ps
module pwr_seq_controller #(
    parameter int SETUP_CYC = pwr_halt_pkg::SETUP_CYCLES,
    parameter int HOLD_CYC = pwr_halt_pkg::HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    pwr_link_if.controller link,
    input wire logic req_ram_down, // pulse: enter ram retention
    input wire logic req_all_down, // pulse: enter full-state hold
    input wire logic req_wake, // pulse: leave power-down
    output logic busy, // sequence in progress
    output logic powered_down // device oscillator stopped
);
    localparam int TW = 18;
    pwr_halt_pkg::seq_t seq, next_seq;
    logic load;
    logic [TW-1:0] load_value;
    logic done;
    logic ps_n, next_ps_n, rs_n, next_rs_n, ss_n, next_ss_n;
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_seq = seq;
        next_ps_n = ps_n;
        next_rs_n = rs_n;
        next_ss_n = ss_n;
        load = 1'b0;
        load_value = TW'(HOLD_CYC);
        case (seq)
            pwr_halt_pkg::SEQ_IDLE: begin
                if (req_ram_down) begin
                    next_rs_n = 1'b0; // [R1] reset first
                    load = 1'b1;
                    load_value = TW'(SETUP_CYC); // [R6]
                    next_seq = pwr_halt_pkg::SEQ_RST_SETUP;
                end else if (req_all_down) begin
                    next_ss_n = 1'b0; // [R7] single step first
                    load = 1'b1;
                    load_value = TW'(HOLD_CYC); // [R10]
                    next_seq = pwr_halt_pkg::SEQ_SS_SETUP;
                end
            end
            pwr_halt_pkg::SEQ_RST_SETUP: begin
                if (done) begin
                    next_ps_n = 1'b0; // [R1]
                    next_seq = pwr_halt_pkg::SEQ_RAM_DOWN;
                end
            end
            pwr_halt_pkg::SEQ_RAM_DOWN: begin
                if (req_wake) begin
                    next_ps_n = 1'b1; // [R3] power save first
                    load = 1'b1; // [R5]
                    next_seq = pwr_halt_pkg::SEQ_RST_HOLD;
                end
            end
            pwr_halt_pkg::SEQ_RST_HOLD: begin
                if (done) begin
                    next_rs_n = 1'b1; // [R3] [R5]
                    next_seq = pwr_halt_pkg::SEQ_IDLE;
                end
            end
            pwr_halt_pkg::SEQ_SS_SETUP: begin
                if (done) begin
                    next_ps_n = 1'b0; // [R7] [R10]
                    next_seq = pwr_halt_pkg::SEQ_ALL_DOWN;
                end
            end
            pwr_halt_pkg::SEQ_ALL_DOWN: begin
                if (req_wake) begin
                    next_ps_n = 1'b1; // [R8]
                    load = 1'b1; // [R10]
                    next_seq = pwr_halt_pkg::SEQ_SS_HOLD;
                end
            end
            pwr_halt_pkg::SEQ_SS_HOLD: begin
                if (done) begin
                    next_ss_n = 1'b1; // [R8] [R10]
                    next_seq = pwr_halt_pkg::SEQ_IDLE;
                end
            end
            default: begin
                next_seq = pwr_halt_pkg::SEQ_IDLE;
            end
        endcase
    end
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq <= pwr_halt_pkg::SEQ_IDLE;
            ps_n <= 1'b1;
            rs_n <= 1'b1;
            ss_n <= 1'b1;
        end else begin
            seq <= next_seq;
            ps_n <= next_ps_n;
            rs_n <= next_rs_n;
            ss_n <= next_ss_n;
        end
    end
    pwr_seq_timer #(.WIDTH(TW)) wait_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(load),
        .load_value(load_value),
        .done(done)
    );
    assign link.power_save_input_n = ps_n;
    assign link.reset_n = rs_n;
    assign link.single_step_input_n = ss_n;
    assign busy = (seq != pwr_halt_pkg::SEQ_IDLE);
    assign powered_down = !link.osc_running;
endmodule : pwr_seq_controller

// file: dv/pwr_link_chk.sv
// checker: order and timing on the power link
// assumes: the signals of pwr_link_if, all on core_clk
`timescale 1ns/1ps
module pwr_link_chk #(
    parameter int SETUP_CYC = 20,
    parameter int HOLD_CYC = 5
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic power_save_input_n,
    input wire logic single_step_input_n,
    input wire logic reset_n,
    input wire logic reset_pullup_en,
    input wire logic single_step_pullup_en,
    input wire logic osc_running
);
    int rst_lo; // cycles reset has been low
    int ss_lo; // cycles single step has been low
    int ps_hi; // cycles power save has been high
    // run lengths of each link level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_lo <= 0;
            ss_lo <= 0;
            ps_hi <= 0;
        end else begin
            rst_lo <= reset_n ? 0 : rst_lo + 1;
            ss_lo <= single_step_input_n ? 0 : ss_lo + 1;
            ps_hi <= power_save_input_n ? ps_hi + 1 : 0;
        end
    end
    // ----------------------------------------------------------------
    // link assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_enter_order: assert property (
        $fell(power_save_input_n) |-> !reset_n || !single_step_input_n)
        else $error("entry out of order");
    a_ram_setup: assert property (
        $fell(power_save_input_n) && single_step_input_n |->
        rst_lo >= SETUP_CYC) else $error("reset setup too short");
    a_all_setup: assert property (
        $fell(power_save_input_n) && reset_n |-> ss_lo >= HOLD_CYC)
        else $error("ss setup too short");
    a_reset_after_ps: assert property (
        $rose(reset_n) |-> ps_hi >= HOLD_CYC)
        else $error("reset released early");
    a_ss_after_ps: assert property (
        $rose(single_step_input_n) |-> ps_hi >= HOLD_CYC)
        else $error("ss released early");
    a_osc_stops: assert property (
        $fell(power_save_input_n) |-> ##[0:2] !osc_running)
        else $error("oscillator still running");
    a_pullups_off: assert property (
        !osc_running |-> !reset_pullup_en && !single_step_pullup_en)
        else $error("pull-up on while stopped");
    a_osc_restarts: assert property (
        $rose(power_save_input_n) |-> ##[0:2] osc_running)
        else $error("oscillator did not restart");
endmodule : pwr_link_chk

// file: dv/mcu_power_down_and_halt_control_test.sv
// testbench: both ends joined by the link, halt and power-down runs
// assumes: core package, interface, both ends, and the link checker
`timescale 1ns/1ps
module mcu_power_down_and_halt_control_test;
    localparam int SETUP_SIM = 20; // shortened 10 ms setup
    localparam int HOLD_SIM = 5; // shortened 10 us hold
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic opcode_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic irq_n = 1'b1; // interrupt, active low
    logic ei = 1'b0;
    logic t1 = 1'b0;
    logic ea = 1'b0;
    logic [7:0] bus_out = 8'h00;
    logic [7:0] q1_out = 8'h00;
    logic [7:0] q2_out = 8'h00;
    logic t0_out = 1'b0;
    logic [4:0] strb = 5'h10; // ale high, other strobes active
    logic [2:0] req = 3'h0; // ram down, all down, wake
    logic run_enable, core_init, irq_pending, ram_write_allow, busy;
    logic test_one_seen, external_access_seen, powered_down;
    logic [11:0] pc_value;
    logic [7:0] bus_port_lines, first_quasi_port, second_quasi_port;
    logic bus_port_lines_oe, first_quasi_port_oe, second_quasi_port_oe;
    logic test_zero_pin, test_zero_pin_oe, strobes_oe;
    logic read_strobe_n, write_strobe_n, expander_strobe_n;
    logic program_store_strobe_n, address_latch_strobe;
    logic [2:0] mode_code;
    logic [23:0] pins;
    logic [7:0] op;
    int fails = 0, checks_done = 0, n_init = 0, n_irq = 0, i0, i1;
    always #25 core_clk = ~core_clk;
    pwr_link_if link ();
    pwr_halt_device pwr_halt_device_i (.core_clk, .rst_n, .link(link),
        .opcode_valid, .opcode, .interrupt_request_input_n(irq_n),
        .interrupts_enabled_state(ei), .test_one_input(t1),
        .external_access_input(ea), .bus_out, .first_quasi_out(q1_out),
        .second_quasi_out(q2_out), .test_zero_out(t0_out),
        .strobe_core_n(strb), .run_enable, .core_init, .irq_pending,
        .pc_value, .ram_write_allow, .test_one_seen, .external_access_seen,
        .bus_port_lines, .bus_port_lines_oe, .first_quasi_port,
        .first_quasi_port_oe, .second_quasi_port, .second_quasi_port_oe,
        .test_zero_pin, .test_zero_pin_oe, .read_strobe_n, .write_strobe_n,
        .expander_strobe_n, .program_store_strobe_n, .address_latch_strobe,
        .strobes_oe, .mode_code);
    pwr_seq_controller #(.SETUP_CYC(SETUP_SIM), .HOLD_CYC(HOLD_SIM))
        pwr_seq_controller_i (.core_clk, .rst_n, .link(link),
        .req_ram_down(req[2]), .req_all_down(req[1]), .req_wake(req[0]),
        .busy, .powered_down);
    pwr_link_chk #(.SETUP_CYC(SETUP_SIM), .HOLD_CYC(HOLD_SIM))
        pwr_link_chk_i (.core_clk, .rst_n,
        .power_save_input_n(link.power_save_input_n),
        .single_step_input_n(link.single_step_input_n),
        .reset_n(link.reset_n), .reset_pullup_en(link.reset_pullup_en),
        .single_step_pullup_en(link.single_step_pullup_en),
        .osc_running(link.osc_running));
    // pulses are counted, not caught
    always @(posedge core_clk) begin
        if (core_init === 1'b1) n_init <= n_init + 1;
        if (irq_pending === 1'b1) n_irq <= n_irq + 1;
    end
    // ----------------------------------------------------------------
    // tasks, entered after a falling edge
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic exec(input logic [7:0] code);
        opcode = code;
        opcode_valid = 1'b1;
        tick(1);
        opcode_valid = 1'b0;
    endtask : exec
    // request pulse, then a bounded wait; busy stands while down
    task automatic step(input logic [2:0] r, input logic want);
        req = r;
        tick(1);
        req = 3'h0;
        for (int i = 0; i < 300 && !(busy === want &&
            powered_down === want); i++) tick(1);
        tick(3);
        chk(powered_down, want);
    endtask : step
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #(20000 * 50);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hd4e68664));
        tick(20);
        rst_n = 1'b1;
        tick(3);
        chk(pc_value, pwr_halt_pkg::RESET_VECTOR);
        // halt holds pins; masked irq releases
        pins = 24'($urandom);
        {bus_out, q1_out, q2_out} = pins;
        t0_out = 1'b1;
        tick(2);
        exec(pwr_halt_pkg::HALT_OPCODE);
        {bus_out, q1_out, q2_out} = ~pins;
        {t1, ea, t0_out} = 3'b110;
        tick(4);
        chk(run_enable, 1'b0);
        chk(mode_code, 3'b010);
        chk(link.osc_running, 1'b1);
        chk({bus_port_lines, first_quasi_port, second_quasi_port}, pins);
        chk({test_zero_pin, test_one_seen, external_access_seen}, 3'h4);
        chk({read_strobe_n, write_strobe_n, expander_strobe_n,
            program_store_strobe_n, address_latch_strobe}, 5'h1e);
        irq_n = 1'b0;
        tick(1);
        irq_n = 1'b1;
        tick(2);
        chk(run_enable, 1'b1);
        chk(pc_value, 12'h001);
        chk(n_irq, 0);
        $display("test done: halt masked");
        // full-state power-down keeps pc
        i0 = n_init;
        step(3'b010, 1'b1);
        chk({bus_port_lines_oe, first_quasi_port_oe, second_quasi_port_oe,
            test_zero_pin_oe, strobes_oe}, 5'h00);
        irq_n = 1'b0;
        tick(3);
        chk(mode_code[0], 1'b0);
        irq_n = 1'b1;
        step(3'b001, 1'b0);
        chk({run_enable, pc_value}, 13'h1001);
        chk(n_init, i0);
        $display("test done: all down");
        // ram-retention from halt restarts at zero
        exec(pwr_halt_pkg::HALT_OPCODE);
        step(3'b100, 1'b1);
        chk({ram_write_allow, strobes_oe, bus_port_lines_oe}, 3'h0);
        step(3'b001, 1'b0);
        chk(n_init, i0 + 1);
        chk({run_enable, pc_value}, 13'h1000);
        $display("test done: ram down");
        // other opcodes run; ei irq waits one opcode
        ei = 1'b1;
        repeat (8) begin
            op = 8'($urandom);
            exec((op == 8'h01) ? 8'h00 : op);
            chk(run_enable, 1'b1);
        end
        i1 = n_irq;
        exec(pwr_halt_pkg::HALT_OPCODE);
        irq_n = 1'b0;
        tick(1);
        irq_n = 1'b1;
        tick(3);
        chk(n_irq, i1);
        exec(8'h00);
        tick(3);
        chk(n_irq, i1 + 1);
        $display("test done: halt ei");
        print_verdict();
    end
endmodule : mcu_power_down_and_halt_control_test
